// File: hdl/ppsin_pkg.sv
// Purpose: constants for the peripheral input pin select block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   selector codes are 7 bits wide
`default_nettype none
package ppsin_pkg;
   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [7:0] OFF_EXT_IRQ1   = 8'h00;
   localparam logic [7:0] OFF_EXT_IRQ2   = 8'h04;
   localparam logic [7:0] OFF_TIMER2_CLK = 8'h08;
   localparam logic [7:0] OFF_CAPTURE_12 = 8'h0C;
   localparam logic [7:0] OFF_CAPTURE_34 = 8'h10;
   localparam logic [7:0] OFF_CMP_FAULT  = 8'h14;
   localparam logic [7:0] OFF_PWM_FAULT  = 8'h18;
   localparam logic [7:0] OFF_ENC_PHASE  = 8'h1C;
   localparam logic [7:0] OFF_ENC_IDXHOM = 8'h20;
   localparam logic [7:0] OFF_UART1_RX   = 8'h24;
   localparam int         ADDR_W         = 8;
   // -----------------------------------------------------------------
   // field layout and reset
   // -----------------------------------------------------------------
   localparam int         SEL_W          = 7;
   localparam int         LO_POS         = 0;
   localparam int         HI_POS         = 8;
   localparam logic [6:0] SEL_RESET      = 7'h00;
   // -----------------------------------------------------------------
   // selector codes and source space
   // -----------------------------------------------------------------
   localparam logic [6:0] CODE_GROUND    = 7'h00;
   localparam logic [6:0] CODE_COMP_ONE  = 7'h01;
   localparam logic [6:0] CODE_MAX       = 7'h79;
   localparam int         NUM_SRC        = 128;
   localparam int         NUM_PERIPH     = 15;
   // peripheral input indices
   localparam int P_IRQ1 = 0;
   localparam int P_IRQ2 = 1;
   localparam int P_T2CK = 2;
   localparam int P_CAP1 = 3;
   localparam int P_CAP2 = 4;
   localparam int P_CAP3 = 5;
   localparam int P_CAP4 = 6;
   localparam int P_CFLT = 7;
   localparam int P_FLT1 = 8;
   localparam int P_FLT2 = 9;
   localparam int P_QEA  = 10;
   localparam int P_QEB  = 11;
   localparam int P_INDX = 12;
   localparam int P_HOME = 13;
   localparam int P_URX  = 14;
endpackage
`default_nettype wire

// File: hdl/ppsin_route.sv
// Purpose: one peripheral input source multiplexer
// Assumes: source vector already synchronised to pclk
// Notes:   registered output, follows selection one cycle later
`default_nettype none
module ppsin_route (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic [ppsin_pkg::NUM_SRC-1:0]   src,
   input  wire logic [ppsin_pkg::SEL_W-1:0]     sel,
   output var  logic                            periph_in
);
   import ppsin_pkg::*;

   typedef struct packed {
      logic q;
   } ppsin_route_t;

   ppsin_route_t state;
   ppsin_route_t next_state;

   // ground for code zero, comparator for code one, pins beyond
   always_comb begin
      next_state = state;
      if (sel == CODE_GROUND) begin
         next_state.q = 1'b0;
      end else begin
         next_state.q = src[sel];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign periph_in = state.q;
endmodule
`default_nettype wire

// File: hdl/ppsin_top.sv
// Purpose: peripheral input pin select, apb register file and routing
// Assumes: pclk 20 MHz, presetn asynchronous active low
// Notes:   pins pass a two-stage synchroniser before any mux reads them
//
// The register offsets and the APB slave port were decided locally.
`default_nettype none
module ppsin_top (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [ppsin_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                    pwdata,
   input  wire logic [3:0]                     pstrb,
   output var  logic [31:0]                    prdata,
   output var  logic                           pready,
   output var  logic                           pslverr,
   input  wire logic [ppsin_pkg::NUM_SRC-1:0]  remappable_pin,
   input  wire logic                           comparator_one_output,
   output var  logic                           external_irq_one,
   output var  logic                           external_irq_two,
   output var  logic                           timer_two_clock,
   output var  logic                           capture_one,
   output var  logic                           capture_two,
   output var  logic                           capture_three,
   output var  logic                           capture_four,
   output var  logic                           compare_fault_a,
   output var  logic                           pwm_fault_one,
   output var  logic                           pwm_fault_two,
   output var  logic                           encoder_phase_a,
   output var  logic                           encoder_phase_b,
   output var  logic                           encoder_index,
   output var  logic                           encoder_home,
   output var  logic                           uart_one_receive
);
   import ppsin_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [SEL_W-1:0] ext_irq_one_source_sel;
      logic [SEL_W-1:0] ext_irq_two_source_sel;
      logic [SEL_W-1:0] timer_two_clock_source_sel;
      logic [SEL_W-1:0] capture_one_source_sel;
      logic [SEL_W-1:0] capture_two_source_sel;
      logic [SEL_W-1:0] capture_three_source_sel;
      logic [SEL_W-1:0] capture_four_source_sel;
      logic [SEL_W-1:0] compare_fault_a_source_sel;
      logic [SEL_W-1:0] pwm_fault_one_source_sel;
      logic [SEL_W-1:0] pwm_fault_two_source_sel;
      logic [SEL_W-1:0] encoder_phase_a_source_sel;
      logic [SEL_W-1:0] encoder_phase_b_source_sel;
      logic [SEL_W-1:0] encoder_index_source_sel;
      logic [SEL_W-1:0] encoder_home_source_sel;
      logic [SEL_W-1:0] uart_one_receive_source_sel;
      logic [NUM_SRC-1:0] sync_a;
      logic [NUM_SRC-1:0] sync_b;
      logic [31:0]        rdata;
      logic               ready;
      logic               err;
   } ppsin_state_t;

   ppsin_state_t state;
   ppsin_state_t next_state;

   logic [SEL_W-1:0]      sel_vec [NUM_PERIPH];
   logic [NUM_PERIPH-1:0] routed;
   logic [NUM_SRC-1:0]    raw_src;
   logic                  access;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // one register word from two fields; everything else reads zero
   function automatic logic [31:0] pack_word(input logic [SEL_W-1:0] hi,
                                             input logic [SEL_W-1:0] lo);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[HI_POS +: SEL_W] = hi;
      w[LO_POS +: SEL_W] = lo;
      return w;
   endfunction

   // the ten selector words; any other place is refused
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (a <= OFF_UART1_RX);
   endfunction

   // field update honouring byte strobes; only 7 bits are ever kept
   function automatic logic [SEL_W-1:0] upd(input logic [SEL_W-1:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] strb,
                                            input int pos);
      logic [SEL_W-1:0] r;
      r = old;
      if (strb[pos/8]) begin
         r = d[pos +: SEL_W];
      end
      return r;
   endfunction

   // code zero slot is never read, ground is forced in the router;
   // slot one is the comparator, higher slots are remappable pins
   always_comb begin
      raw_src    = remappable_pin;
      raw_src[0] = 1'b0;
      raw_src[1] = comparator_one_output;
   end

   assign access = psel && penable;

   // -----------------------------------------------------------------
   // register file and synchroniser
   // -----------------------------------------------------------------
   always_comb begin
      next_state        = state;
      next_state.sync_a = raw_src;
      next_state.sync_b = state.sync_a;
      // ready one cycle after access starts: zero wait states plus one
      next_state.ready  = access && !state.ready;
      next_state.err    = 1'b0;
      next_state.rdata  = 32'h0000_0000; // read data stands with pready only
      // refusal decided in the first access cycle, shown with pready
      if (access && !state.ready) begin
         next_state.err = !is_mapped(paddr);
      end
      // a write lands on the edge that samples pready high, not before
      if (access && state.ready) begin
         if (pwrite) begin
            // no cross-checking between selectors, any mix accepted
            unique case (paddr)
               OFF_EXT_IRQ1: next_state.ext_irq_one_source_sel =
                  upd(state.ext_irq_one_source_sel, pwdata, pstrb, HI_POS);
               OFF_EXT_IRQ2: next_state.ext_irq_two_source_sel =
                  upd(state.ext_irq_two_source_sel, pwdata, pstrb, LO_POS);
               OFF_TIMER2_CLK: next_state.timer_two_clock_source_sel =
                  upd(state.timer_two_clock_source_sel, pwdata, pstrb, LO_POS);
               OFF_CAPTURE_12: begin
                  next_state.capture_two_source_sel =
                     upd(state.capture_two_source_sel, pwdata, pstrb, HI_POS);
                  next_state.capture_one_source_sel =
                     upd(state.capture_one_source_sel, pwdata, pstrb, LO_POS);
               end
               OFF_CAPTURE_34: begin
                  next_state.capture_four_source_sel =
                     upd(state.capture_four_source_sel, pwdata, pstrb, HI_POS);
                  next_state.capture_three_source_sel =
                     upd(state.capture_three_source_sel, pwdata, pstrb, LO_POS);
               end
               OFF_CMP_FAULT: next_state.compare_fault_a_source_sel =
                  upd(state.compare_fault_a_source_sel, pwdata, pstrb, LO_POS);
               OFF_PWM_FAULT: begin
                  next_state.pwm_fault_two_source_sel =
                     upd(state.pwm_fault_two_source_sel, pwdata, pstrb, HI_POS);
                  next_state.pwm_fault_one_source_sel =
                     upd(state.pwm_fault_one_source_sel, pwdata, pstrb, LO_POS);
               end
               OFF_ENC_PHASE: begin
                  next_state.encoder_phase_b_source_sel =
                     upd(state.encoder_phase_b_source_sel, pwdata, pstrb, HI_POS);
                  next_state.encoder_phase_a_source_sel =
                     upd(state.encoder_phase_a_source_sel, pwdata, pstrb, LO_POS);
               end
               OFF_ENC_IDXHOM: begin
                  next_state.encoder_home_source_sel =
                     upd(state.encoder_home_source_sel, pwdata, pstrb, HI_POS);
                  next_state.encoder_index_source_sel =
                     upd(state.encoder_index_source_sel, pwdata, pstrb, LO_POS);
               end
               OFF_UART1_RX: next_state.uart_one_receive_source_sel =
                  upd(state.uart_one_receive_source_sel, pwdata, pstrb, LO_POS);
               default: next_state.err = 1'b0; // refused place, nothing kept
            endcase
         end
      end
      if (access && !state.ready) begin
         if (!pwrite) begin
            unique case (paddr)
               OFF_EXT_IRQ1:   next_state.rdata =
                  pack_word(state.ext_irq_one_source_sel, SEL_RESET);
               OFF_EXT_IRQ2:   next_state.rdata =
                  pack_word(SEL_RESET, state.ext_irq_two_source_sel);
               OFF_TIMER2_CLK: next_state.rdata =
                  pack_word(SEL_RESET, state.timer_two_clock_source_sel);
               OFF_CAPTURE_12: next_state.rdata =
                  pack_word(state.capture_two_source_sel, state.capture_one_source_sel);
               OFF_CAPTURE_34: next_state.rdata =
                  pack_word(state.capture_four_source_sel,
                            state.capture_three_source_sel);
               OFF_CMP_FAULT:  next_state.rdata =
                  pack_word(SEL_RESET, state.compare_fault_a_source_sel);
               OFF_PWM_FAULT:  next_state.rdata =
                  pack_word(state.pwm_fault_two_source_sel,
                            state.pwm_fault_one_source_sel);
               OFF_ENC_PHASE:  next_state.rdata =
                  pack_word(state.encoder_phase_b_source_sel,
                            state.encoder_phase_a_source_sel);
               OFF_ENC_IDXHOM: next_state.rdata =
                  pack_word(state.encoder_home_source_sel,
                            state.encoder_index_source_sel);
               OFF_UART1_RX:   next_state.rdata =
                  pack_word(SEL_RESET, state.uart_one_receive_source_sel);
               default:        next_state.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // every selector starts at ground, synchroniser cleared too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // -----------------------------------------------------------------
   // routing
   // -----------------------------------------------------------------
   always_comb begin
      sel_vec[P_IRQ1] = state.ext_irq_one_source_sel;
      sel_vec[P_IRQ2] = state.ext_irq_two_source_sel;
      sel_vec[P_T2CK] = state.timer_two_clock_source_sel;
      sel_vec[P_CAP1] = state.capture_one_source_sel;
      sel_vec[P_CAP2] = state.capture_two_source_sel;
      sel_vec[P_CAP3] = state.capture_three_source_sel;
      sel_vec[P_CAP4] = state.capture_four_source_sel;
      sel_vec[P_CFLT] = state.compare_fault_a_source_sel;
      sel_vec[P_FLT1] = state.pwm_fault_one_source_sel;
      sel_vec[P_FLT2] = state.pwm_fault_two_source_sel;
      sel_vec[P_QEA]  = state.encoder_phase_a_source_sel;
      sel_vec[P_QEB]  = state.encoder_phase_b_source_sel;
      sel_vec[P_INDX] = state.encoder_index_source_sel;
      sel_vec[P_HOME] = state.encoder_home_source_sel;
      sel_vec[P_URX]  = state.uart_one_receive_source_sel;
   end

   // one mux per input; all read the same source vector freely
   for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_route
      ppsin_route u_route (
         .pclk      (pclk),
         .presetn   (presetn),
         .src       (state.sync_b),
         .sel       (sel_vec[i]),
         .periph_in (routed[i])
      );
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign prdata           = state.rdata;
   assign pready           = state.ready;
   assign pslverr          = state.err;
   assign external_irq_one = routed[P_IRQ1];
   assign external_irq_two = routed[P_IRQ2];
   assign timer_two_clock  = routed[P_T2CK];
   assign capture_one      = routed[P_CAP1];
   assign capture_two      = routed[P_CAP2];
   assign capture_three    = routed[P_CAP3];
   assign capture_four     = routed[P_CAP4];
   assign compare_fault_a  = routed[P_CFLT];
   assign pwm_fault_one    = routed[P_FLT1];
   assign pwm_fault_two    = routed[P_FLT2];
   assign encoder_phase_a  = routed[P_QEA];
   assign encoder_phase_b  = routed[P_QEB];
   assign encoder_index    = routed[P_INDX];
   assign encoder_home     = routed[P_HOME];
   assign uart_one_receive = routed[P_URX];

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   chk_ground_code: assert property (@(posedge pclk) disable iff (!presetn)
      state.uart_one_receive_source_sel == CODE_GROUND |=> !uart_one_receive)
      else $error("ground code did not hold input low");
   chk_cmp_route: assert property (@(posedge pclk) disable iff (!presetn)
      state.ext_irq_two_source_sel == CODE_COMP_ONE |=>
      external_irq_two == $past(state.sync_b[1]))
      else $error("comparator not routed on code one");
   chk_pin_route: assert property (@(posedge pclk) disable iff (!presetn)
      state.capture_one_source_sel == CODE_MAX |=>
      capture_one == $past(state.sync_b[121]))
      else $error("pin 121 not routed");
   chk_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:15] == 17'h0 && prdata[7] == 1'b0)
      else $error("unimplemented bits read nonzero");
   chk_external_irq_one_field: assert property (@(posedge pclk) disable iff (!presetn)
      access && pready && pwrite && paddr == OFF_EXT_IRQ1 && pstrb[1] |=>
      state.ext_irq_one_source_sel == $past(pwdata[14:8]))
      else $error("int one field not written");
   chk_external_irq_two_field: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready && !pwrite && paddr == OFF_EXT_IRQ2 |=>
      prdata == {25'h0, state.ext_irq_two_source_sel})
      else $error("int two readback wrong");
   chk_t2_field: assert property (@(posedge pclk) disable iff (!presetn)
      access && pready && pwrite && paddr == OFF_TIMER2_CLK && pstrb[0] |=>
      state.timer_two_clock_source_sel == $past(pwdata[6:0]))
      else $error("timer clock field not written");
   chk_cap4_field: assert property (@(posedge pclk) disable iff (!presetn)
      access && pready && pwrite && paddr == OFF_CAPTURE_34 && pstrb[1] |=>
      state.capture_four_source_sel == $past(pwdata[14:8]))
      else $error("capture four field not written");
   chk_cap3_field: assert property (@(posedge pclk) disable iff (!presetn)
      access && pready && pwrite && paddr == OFF_CAPTURE_34 && pstrb[0] |=>
      state.capture_three_source_sel == $past(pwdata[6:0]))
      else $error("capture three field not written");
   chk_compare_fault_a_field: assert property (@(posedge pclk) disable iff (!presetn)
      access && pready && pwrite && paddr == OFF_CMP_FAULT && pstrb[0] |=>
      state.compare_fault_a_source_sel == $past(pwdata[6:0]))
      else $error("fault a field not written");
   chk_urx_field: assert property (@(posedge pclk) disable iff (!presetn)
      access && pready && pwrite && paddr == OFF_UART1_RX && pstrb[0] |=>
      state.uart_one_receive_source_sel == $past(pwdata[6:0]))
      else $error("uart field not written");
   chk_shared_pin: assert property (@(posedge pclk) disable iff (!presetn)
      state.capture_one_source_sel == state.capture_two_source_sel |=>
      capture_one == capture_two)
      else $error("shared selection differs");
   chk_reset_zero: assert property (@(posedge pclk)
      $rose(presetn) |-> state.ext_irq_one_source_sel == SEL_RESET && !external_irq_one)
      else $error("selector not cleared by reset");
   chk_follow_next: assert property (@(posedge pclk) disable iff (!presetn)
      state.encoder_index_source_sel != CODE_GROUND |=>
      encoder_index == $past(state.sync_b[state.encoder_index_source_sel]))
      else $error("input did not follow selection");
endmodule
`default_nettype wire

// File: verif/ppsin_pins.sv
// Purpose: far-side model, remappable pins and comparator output
// Assumes: the bench sets the levels just after a rising edge
// Notes:   every pin is always driven, so none floats to an unknown
`default_nettype none
module ppsin_pins (
   input  wire logic         pclk,
   input  wire logic [127:0] level,
   input  wire logic         cmp_level,
   output var  logic [127:0] remappable_pin,
   output var  logic         comparator_one_output
);
   timeunit 1ns;
   timeprecision 1ns;
   // pins move right after the edge, far from the synchroniser sample point
   always_ff @(posedge pclk) begin
      remappable_pin        <= level;
      comparator_one_output <= cmp_level;
   end
endmodule
`default_nettype wire

// File: verif/ppsin_top_tb.sv
// Purpose: self-checking bench for the peripheral input pin select
// Assumes: apb answers with one wait state; pins pass a 2-stage sync
// Notes:   random selector words with hand-made corner rounds
`default_nettype none
module ppsin_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ppsin_pkg::*;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0000_0000;
   logic [3:0]   pstrb = 4'hF;
   logic [127:0] level = '1;
   logic         cmp_level = 1'b1;
   logic [31:0]  prdata, seed;
   logic         pready, pslverr, comparator_one_output;
   logic [127:0] remappable_pin;
   wire  [14:0]  got;
   logic [31:0]  model [10];
   int           miscompares = 0, total_checks = 0, cycles = 0;
   localparam int         RIDX [15] = '{0, 1, 2, 3, 3, 4, 4, 5, 6, 6, 7, 7, 8, 8, 9};
   localparam logic [14:0] HI      = 15'b010_1010_0101_0001;
   ppsin_pins u_ppsin_pins (.pclk(pclk), .level(level), .cmp_level(cmp_level),
      .remappable_pin(remappable_pin), .comparator_one_output(comparator_one_output));
   ppsin_top u_ppsin_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .remappable_pin(remappable_pin),
      .comparator_one_output(comparator_one_output), .external_irq_one(got[P_IRQ1]),
      .external_irq_two(got[P_IRQ2]), .timer_two_clock(got[P_T2CK]),
      .capture_one(got[P_CAP1]), .capture_two(got[P_CAP2]), .capture_three(got[P_CAP3]),
      .capture_four(got[P_CAP4]), .compare_fault_a(got[P_CFLT]),
      .pwm_fault_one(got[P_FLT1]), .pwm_fault_two(got[P_FLT2]),
      .encoder_phase_a(got[P_QEA]), .encoder_phase_b(got[P_QEB]),
      .encoder_index(got[P_INDX]), .encoder_home(got[P_HOME]), .uart_one_receive(got[P_URX]));
   // clock and hang guard, the run needs about 2300 cycles
   initial forever #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 10000) begin
         miscompares++;
         test_done();
      end
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // implemented bits of each selector word
   function automatic logic [31:0] fmask(input int i);
      case (i)
         0: return 32'h0000_7F00;
         1, 2, 5, 9: return 32'h0000_007F;
         default: return 32'h0000_7F7F;
      endcase
   endfunction
   function automatic logic exp_out(input int p);
      logic [6:0] s;
      s = HI[p] ? model[RIDX[p]][14:8] : model[RIDX[p]][6:0];
      if (s == CODE_GROUND) return 1'b0;
      if (s == CODE_COMP_ONE) return cmp_level;
      return level[s];
   endfunction
   task automatic chk32(input string what, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic chk1(input string what, input logic e, input logic s);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %b seen %b", what, e, s);
      end
   endtask
   // one apb transfer; waits an edge first so no signal is set twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no assumed latency: the wait ends when pready is seen high, or at the bench timeout
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic zero_check();
      logic [31:0] r;
      logic        e;
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0000_0000, r, e);
         chk32("select word after reset", 32'h0000_0000, r);
      end
      for (int p = 0; p < NUM_PERIPH; p++) chk1("routed input after reset", 1'b0, got[p]);
   endtask
   task automatic test_done();
      if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] r, d;
      logic        e;
      seed = 32'hBB95_5A6A;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      zero_check();
      // rounds 0..2 put every selector on code 121, code one, code zero
      for (int k = 0; k < 24; k++) begin
         level <= {rnd(), rnd(), rnd(), rnd()};
         r = rnd();
         cmp_level <= r[0];
         for (int i = 0; i < 10; i++) begin
            d = (k == 0) ? 32'hFFFF_F9F9 : (k == 1) ? 32'hA5A5_8181 :
                (k == 2) ? 32'hFFFF_8080 : rnd();
            model[i] = d & fmask(i);
            apb(1'b1, 8'(4 * i), d, r, e);
            chk1("write error flag", 1'b0, e);
         end
         // unmapped place: refused, and no selector may change
         apb(1'b1, 8'h28 + 8'(4 * k), rnd(), r, e);
         chk1("unmapped write error", 1'b1, e);
         apb(1'b0, 8'h28 + 8'(4 * k), 32'h0000_0000, r, e);
         chk1("unmapped read error", 1'b1, e);
         chk32("unmapped read data", 32'h0000_0000, r);
         for (int i = 0; i < 10; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000, r, e);
            chk32("select word", model[i], r);
         end
         repeat (5) @(posedge pclk);
         for (int p = 0; p < NUM_PERIPH; p++) chk1("routed input", exp_out(p), got[p]);
      end
      // second reset in mid-run clears everything again
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      zero_check();
      test_done();
   end
endmodule
`default_nettype wire
